// >>> rtl/wdp_watchdog_power.sv
// watchdog timer, idle/stop power modes, band-gap and ring oscillator control
`timescale 1ns/10ps
//
// Operation
// - watchdog interval is 2^17, 2^20, 2^23 or 2^26 clocks by select field.
// - at interval end raise interrupt, then reset core 512 clocks later unless restarted.
// - interrupt flag sets exactly 512 clocks before the watchdog reset.
// - watchdog reset sets a sticky reset-cause flag for software.
// - watchdog runs only while enable bit set; enable writes need timed access.
// - restart bit starts a fresh full interval of the selected length.
// - interrupt request reaches core only when its enable bit is set.
// - power control bit 0 enters idle; clocks, timers, serial keep running.
// - idle ends on any enabled interrupt, including watchdog, or any reset.
// - power control bit 1 enters stop; oscillator and all clocks halt.
// - stop ends only on external interrupt or reset.
// - band-gap select resets to 0; when 1 reference stays on in stop.
// - band-gap select has no effect outside stop.
// - ring select set makes stop wake-up run from ring oscillator at once.
// - after ring wake-up switch to crystal after 65536 crystal clocks.
// - re-entering stop before handover turns all clocks off again.
// - read-only ring-mode bit is 1 while clocked from ring oscillator.
// - AAh then 55h to timed-access register opens a two-cycle protected write window.
module wdp_watchdog_power #(
    parameter int WDOG_GRACE    = wdp_pkg::WDOG_GRACE_CLK,
    parameter int RING_HANDOVER = wdp_pkg::RING_HANDOVER_CLK,
    parameter int EXP_SEL0      = wdp_pkg::WDOG_EXP_SEL0,
    parameter int EXP_SEL1      = wdp_pkg::WDOG_EXP_SEL1,
    parameter int EXP_SEL2      = wdp_pkg::WDOG_EXP_SEL2,
    parameter int EXP_SEL3      = wdp_pkg::WDOG_EXP_SEL3
) (
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    input  wire wdp_pkg::wdp_sfr_req_type sfr_req,
    output logic [7:0]                    sfr_rdata,
    input  wire logic                     ext_irq_pin,
    input  wire logic                     other_irq_pending,
    output logic                          wdog_timeout_irq,
    output logic                          wdog_reset_req,
    output logic                          cpu_idle,
    output logic                          clocks_halted,
    output logic                          bandgap_on,
    output logic                          ring_clk_sel
);
    localparam int CNT_W = 27;
    localparam int RING_W = 17;

    // external interrupt pin is asynchronous
    logic ext_meta_reg;
    logic ext_sync_reg;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
        end else begin
            ext_meta_reg <= ext_irq_pin;
            ext_sync_reg <= ext_meta_reg;
        end
    end

    wire wr = sfr_req.wr;
    wire [7:0] wa = sfr_req.addr;
    wire [7:0] wd = sfr_req.wdata;

    // one strobe per register; an unmapped address raises none
    logic wr_ta;
    logic wr_clock_control_reg;
    logic wr_wdog_control_reg;
    logic wr_extended_interrupt_flags;
    logic wr_eie;
    logic wr_power_control;
    always_comb begin
        wr_ta    = 1'b0;
        wr_clock_control_reg = 1'b0;
        wr_wdog_control_reg = 1'b0;
        wr_extended_interrupt_flags  = 1'b0;
        wr_eie   = 1'b0;
        wr_power_control  = 1'b0;
        if (wa == wdp_pkg::ADDR_TIMED_ACCESS) begin
            wr_ta = wr;
        end else if (wa == wdp_pkg::ADDR_CLOCK_CONTROL) begin
            wr_clock_control_reg = wr;
        end else if (wa == wdp_pkg::ADDR_WDOG_CONTROL) begin
            wr_wdog_control_reg = wr;
        end else if (wa == wdp_pkg::ADDR_EXT_IRQ_FLAGS) begin
            wr_extended_interrupt_flags = wr;
        end else if (wa == wdp_pkg::ADDR_EXT_IRQ_ENABLE) begin
            wr_eie = wr;
        end else if (wa == wdp_pkg::ADDR_POWER_CONTROL) begin
            wr_power_control = wr;
        end
    end

    // timed access
    logic       ta_armed_reg;
    logic [1:0] ta_window_reg;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ta_armed_reg  <= 1'b0;
            ta_window_reg <= 2'h0;
        end else if (wr_ta) begin
            // any other key byte disarms the sequence
            ta_armed_reg  <= (wd == wdp_pkg::TA_KEY_FIRST);
            ta_window_reg <= (ta_armed_reg && wd == wdp_pkg::TA_KEY_SECOND) ?
                             2'(wdp_pkg::TA_WINDOW_CYC) : 2'h0;
        end else if (ta_window_reg != 2'h0) begin
            ta_window_reg <= ta_window_reg - 2'h1;
        end
    end
    wire ta_open = (ta_window_reg != 2'h0);

    // register state
    logic       sel_hi_reg;
    logic       sel_lo_reg;
    logic       wdog_enable_reg;
    logic       irq_flag_reg;
    logic       rst_flag_reg;
    logic       irq_en_reg;
    logic       bgs_reg;
    logic       ring_osc_select_reg;
    logic       idle_reg;
    logic       stop_reg;
    logic       ring_reg;
    logic [CNT_W-1:0]  wdog_cnt_reg;
    logic [9:0]        grace_cnt_reg;
    logic              grace_reg;
    logic [RING_W-1:0] ring_cnt_reg;

    logic [CNT_W-1:0] interval_last;
    always_comb begin
        case ({sel_hi_reg, sel_lo_reg})
            2'b00:   interval_last = CNT_W'((64'd1 << EXP_SEL0) - 64'd1);
            2'b01:   interval_last = CNT_W'((64'd1 << EXP_SEL1) - 64'd1);
            2'b10:   interval_last = CNT_W'((64'd1 << EXP_SEL2) - 64'd1);
            default: interval_last = CNT_W'((64'd1 << EXP_SEL3) - 64'd1);
        endcase
    end

    // frozen in stop because the crystal is halted there
    wire running    = wdog_enable_reg && !stop_reg;
    // restart is a strobe, never stored, so its bit always reads 0
    wire restart    = wr_wdog_control_reg && ta_open && wd[wdp_pkg::WDOG_CONTROL_REG_RESTART_BIT];
    wire interval_done = running && !grace_reg && (wdog_cnt_reg == interval_last);
    wire grace_done = running && grace_reg && (grace_cnt_reg == 10'(WDOG_GRACE - 1));

    // a new select applies to the count already running
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sel_hi_reg <= 1'b0;
            sel_lo_reg <= 1'b0;
        end else if (wr_clock_control_reg) begin
            sel_hi_reg <= wd[wdp_pkg::CLOCK_CONTROL_REG_SEL_HI_BIT];
            sel_lo_reg <= wd[wdp_pkg::CLOCK_CONTROL_REG_SEL_LO_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wdog_enable_reg <= 1'b0;
            irq_en_reg      <= 1'b0;
        end else begin
            if (wr_wdog_control_reg && ta_open)
                wdog_enable_reg <= wd[wdp_pkg::WDOG_CONTROL_REG_ENABLE_BIT];
            if (wr_eie)
                irq_en_reg <= wd[wdp_pkg::EIE_WDOG_BIT];
        end
    end

    // interval counter; holds its last value while the grace count runs
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wdog_cnt_reg <= '0;
        end else if (restart || !wdog_enable_reg || grace_done) begin
            wdog_cnt_reg <= '0;
        end else if (running && !grace_reg && !interval_done) begin
            wdog_cnt_reg <= wdog_cnt_reg + CNT_W'(1);
        end
    end

    // grace counter: the last clocks before the reset request
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            grace_cnt_reg <= 10'h000;
            grace_reg     <= 1'b0;
        end else if (restart || !wdog_enable_reg || grace_done) begin
            grace_cnt_reg <= 10'h000;
            grace_reg     <= 1'b0;
        end else if (interval_done) begin
            grace_reg     <= 1'b1;
        end else if (running && grace_reg) begin
            grace_cnt_reg <= grace_cnt_reg + 10'h001;
        end
    end

    // reset pulse toward the system reset logic; flag kept here
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            wdog_reset_req <= 1'b0;
        else
            wdog_reset_req <= grace_done;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            irq_flag_reg <= 1'b0;
        else if (interval_done)
            irq_flag_reg <= 1'b1;
        else if (wr_wdog_control_reg && ta_open)
            irq_flag_reg <= wd[wdp_pkg::WDOG_CONTROL_REG_IRQFLAG_BIT];
    end

    // set wins over a clearing write in the same cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            rst_flag_reg <= 1'b0;
        else if (grace_done)
            rst_flag_reg <= 1'b1;
        else if (wr_wdog_control_reg && !wd[wdp_pkg::WDOG_CONTROL_REG_RSTFLAG_BIT])
            rst_flag_reg <= 1'b0;
    end

    always_comb wdog_timeout_irq = irq_flag_reg && irq_en_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bgs_reg  <= 1'b0;
            ring_osc_select_reg <= 1'b0;
        end else if (wr_extended_interrupt_flags) begin
            if (ta_open)
                bgs_reg <= wd[wdp_pkg::EXTENDED_INTERRUPT_FLAGS_BGS_BIT];
            ring_osc_select_reg <= wd[wdp_pkg::EXTENDED_INTERRUPT_FLAGS_RING_OSC_SELECT_BIT];
        end
    end

    // band-gap always on outside stop
    always_comb bandgap_on = !stop_reg || bgs_reg;

    // the synchronised pin wakes idle as well as stop
    wire wake_idle = wdog_timeout_irq || other_irq_pending || ext_sync_reg;
    wire wake_stop = ext_sync_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            idle_reg <= 1'b0;
        end else if (wr_power_control && wd[wdp_pkg::POWER_CONTROL_IDLE_BIT] && !wd[wdp_pkg::POWER_CONTROL_STOP_BIT]) begin
            idle_reg <= 1'b1;
        end else if (wake_idle) begin
            idle_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stop_reg <= 1'b0;
        end else if (wr_power_control && wd[wdp_pkg::POWER_CONTROL_STOP_BIT]) begin
            stop_reg <= 1'b1;
        end else if (wake_stop) begin
            stop_reg <= 1'b0;
        end
    end

    // ring oscillator handover; the count starts over on every wake
    // so a stop before handover never shortens the settling time
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ring_reg     <= 1'b0;
            ring_cnt_reg <= '0;
        end else if (stop_reg && wake_stop) begin
            ring_reg     <= ring_osc_select_reg;
            ring_cnt_reg <= '0;
        end else if (ring_reg && !stop_reg) begin
            ring_cnt_reg <= ring_cnt_reg + RING_W'(1);
            if (ring_cnt_reg == RING_W'(RING_HANDOVER - 1))
                ring_reg <= 1'b0;
        end
    end

    always_comb cpu_idle      = idle_reg;
    always_comb clocks_halted = stop_reg;
    always_comb ring_clk_sel  = ring_reg && !stop_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= wdp_pkg::RESET_VALUE;
        end else if (sfr_req.rd) begin
            if (sfr_req.addr == wdp_pkg::ADDR_POWER_CONTROL)
                sfr_rdata <= {6'h00, stop_reg, idle_reg};
            else if (sfr_req.addr == wdp_pkg::ADDR_CLOCK_CONTROL)
                sfr_rdata <= {sel_hi_reg, sel_lo_reg, 6'h00};
            else if (sfr_req.addr == wdp_pkg::ADDR_EXT_IRQ_FLAGS)
                sfr_rdata <= {5'h00, ring_clk_sel, ring_osc_select_reg, bgs_reg};
            else if (sfr_req.addr == wdp_pkg::ADDR_WDOG_CONTROL)
                sfr_rdata <= {4'h0, irq_flag_reg, rst_flag_reg, wdog_enable_reg, 1'b0};
            else if (sfr_req.addr == wdp_pkg::ADDR_EXT_IRQ_ENABLE)
                sfr_rdata <= {3'h0, irq_en_reg, 4'h0};
            else
                sfr_rdata <= 8'h00;
        end
    end
endmodule // wdp_watchdog_power

// >>> rtl/wdp_pkg.sv
// package: register map, field positions, reset values and counts for the watchdog and power-mode block
package wdp_pkg;
    localparam logic [7:0] ADDR_POWER_CONTROL  = 8'h87;
    localparam logic [7:0] ADDR_CLOCK_CONTROL  = 8'h8e;
    localparam logic [7:0] ADDR_EXT_IRQ_FLAGS  = 8'h91;
    localparam logic [7:0] ADDR_TIMED_ACCESS   = 8'hc7;
    localparam logic [7:0] ADDR_WDOG_CONTROL   = 8'hd8;
    localparam logic [7:0] ADDR_EXT_IRQ_ENABLE = 8'he8;

    localparam logic [7:0] TA_KEY_FIRST  = 8'haa;
    localparam logic [7:0] TA_KEY_SECOND = 8'h55;
    localparam int         TA_WINDOW_CYC = 2;

    // power control
    localparam int POWER_CONTROL_IDLE_BIT = 0;
    localparam int POWER_CONTROL_STOP_BIT = 1;
    // clock control
    localparam int CLOCK_CONTROL_REG_SEL_LO_BIT = 6;
    localparam int CLOCK_CONTROL_REG_SEL_HI_BIT = 7;
    // extended interrupt flags
    localparam int EXTENDED_INTERRUPT_FLAGS_BGS_BIT  = 0;
    localparam int EXTENDED_INTERRUPT_FLAGS_RING_OSC_SELECT_BIT = 1;
    localparam int EXTENDED_INTERRUPT_FLAGS_RING_OSC_ACTIVE_BIT = 2;
    // watchdog control
    localparam int WDOG_CONTROL_REG_RESTART_BIT = 0;
    localparam int WDOG_CONTROL_REG_ENABLE_BIT  = 1;
    localparam int WDOG_CONTROL_REG_RSTFLAG_BIT = 2;
    localparam int WDOG_CONTROL_REG_IRQFLAG_BIT = 3;
    // extended interrupt enable
    localparam int EIE_WDOG_BIT = 4;

    localparam logic [7:0] RESET_VALUE = 8'h00;

    localparam int WDOG_EXP_SEL0 = 17;
    localparam int WDOG_EXP_SEL1 = 20;
    localparam int WDOG_EXP_SEL2 = 23;
    localparam int WDOG_EXP_SEL3 = 26;
    localparam int WDOG_GRACE_CLK = 512;
    localparam int RING_HANDOVER_CLK = 65536;

    typedef enum logic [1:0] {
        WDP_RUN_TYPE_RUN  = 2'b00,
        WDP_RUN_TYPE_IDLE = 2'b01,
        WDP_RUN_TYPE_STOP = 2'b10
    } wdp_mode_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wdp_sfr_req_type;
endpackage

// >>> tb/wdp_checker_sva.sv
// checker: port-level assertions for the watchdog and power-mode block
`timescale 1ns/10ps
module wdp_checker #(
    parameter int RING_HANDOVER = wdp_pkg::RING_HANDOVER_CLK
) (
    input wire logic                     clk_sys,
    input wire logic                     nrst,
    input wire wdp_pkg::wdp_sfr_req_type sfr_req,
    input wire logic [7:0]               sfr_rdata,
    input wire logic                     ext_irq_pin,
    input wire logic                     other_irq_pending,
    input wire logic                     wdog_timeout_irq,
    input wire logic                     wdog_reset_req,
    input wire logic                     cpu_idle,
    input wire logic                     clocks_halted,
    input wire logic                     bandgap_on,
    input wire logic                     ring_clk_sel
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic [31:0] ring_cnt;
    // cycles spent on the ring clock while awake
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            ring_cnt <= '0;
        else
            ring_cnt <= (ring_clk_sel && !clocks_halted) ? ring_cnt + 32'h1 : '0;
    end
    sequence pin_quiet;
        !ext_irq_pin [*3];
    endsequence
    sequence pc_write(int b);
        sfr_req.wr && sfr_req.addr == 8'h87 && sfr_req.wdata[b] && !ext_irq_pin;
    endsequence
    chk_reset_one_cycle: assert property (wdog_reset_req |=> !wdog_reset_req)
        else $error("watchdog reset request longer than one cycle");
    chk_bandgap_awake_on: assert property (!clocks_halted |-> bandgap_on)
        else $error("band-gap off outside stop");
    chk_idle_enter_now: assert property (pc_write(0) ##0 !other_irq_pending && !wdog_timeout_irq |=> cpu_idle)
        else $error("idle not entered");
    chk_idle_wake_irq: assert property (cpu_idle && other_irq_pending |-> ##[1:4] !cpu_idle)
        else $error("idle not left on interrupt");
    chk_stop_enter_now: assert property (pc_write(1) |=> clocks_halted)
        else $error("stop not entered");
    chk_stop_held_quiet: assert property (pin_quiet ##0 clocks_halted |=> clocks_halted)
        else $error("stop left without external interrupt");
    chk_ring_handover_bound: assert property (ring_clk_sel && !clocks_halted |-> ring_cnt < RING_HANDOVER + 2)
        else $error("ring clock kept too long");
    chk_restart_reads_zero: assert property (sfr_req.rd && sfr_req.addr == 8'hd8 |=> !sfr_rdata[0])
        else $error("restart bit read as one");
    chk_ring_status_match: assert property (sfr_req.rd && sfr_req.addr == 8'h91 |=> sfr_rdata[2] == $past(ring_clk_sel))
        else $error("ring status bit differs from ring clock select");
    chk_unmapped_reads_zero: assert property (sfr_req.rd && sfr_req.addr == 8'h00 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // wdp_checker

bind wdp_watchdog_power wdp_checker #(.RING_HANDOVER(RING_HANDOVER)) u_wdp_checker (.clk_sys(clk_sys), .nrst(nrst),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .ext_irq_pin(ext_irq_pin), .other_irq_pending(other_irq_pending),
    .wdog_timeout_irq(wdog_timeout_irq), .wdog_reset_req(wdog_reset_req), .cpu_idle(cpu_idle),
    .clocks_halted(clocks_halted), .bandgap_on(bandgap_on), .ring_clk_sel(ring_clk_sel));

// >>> tb/wdp_watchdog_power_tb.sv
// testbench: self-checking scenarios for the watchdog and power-mode block
`timescale 1ns/10ps
module wdp_watchdog_power_tb;
    localparam int GRACE = 8;
    localparam int HAND  = 16;
    logic                     clk_sys = 1'b0;
    logic                     nrst = 1'b0;
    wdp_pkg::wdp_sfr_req_type sfr_req = '0;
    logic                     ext_irq_pin = 1'b0;
    logic                     other_irq_pending = 1'b0;
    logic [7:0]               sfr_rdata;
    logic                     wdog_timeout_irq, wdog_reset_req, cpu_idle, clocks_halted, bandgap_on, ring_clk_sel;
    int                       err_total = 0;
    int                       n_compared = 0;
    int                       n;
    always #2 clk_sys = ~clk_sys;
    // short intervals keep the run brief: 2^4..2^7, grace 8, handover 16
    wdp_watchdog_power #(.WDOG_GRACE(GRACE), .RING_HANDOVER(HAND), .EXP_SEL0(4), .EXP_SEL1(5), .EXP_SEL2(6),
        .EXP_SEL3(7)) u_wdp_watchdog_power (.clk_sys(clk_sys), .nrst(nrst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .ext_irq_pin(ext_irq_pin), .other_irq_pending(other_irq_pending),
        .wdog_timeout_irq(wdog_timeout_irq), .wdog_reset_req(wdog_reset_req), .cpu_idle(cpu_idle),
        .clocks_halted(clocks_halted), .bandgap_on(bandgap_on), .ring_clk_sel(ring_clk_sel));
    task complete_run;
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task drive(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_req <= '{wr: wr, rd: rd, addr: a, wdata: d};
    endtask
    task sfr_wr(input logic [7:0] a, input logic [7:0] d);
        drive(1'b1, 1'b0, a, d);
        drive(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    // unlock pair back to back, protected write on the very next cycle
    task unlock_wr(input logic [7:0] a, input logic [7:0] d);
        drive(1'b1, 1'b0, 8'hc7, 8'haa);
        drive(1'b1, 1'b0, 8'hc7, 8'h55);
        sfr_wr(a, d);
    endtask
    task read_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        drive(1'b0, 1'b1, a, 8'h00);
        drive(1'b0, 1'b0, 8'h00, 8'h00);
        #1;
        check8(name, exp, sfr_rdata);
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return wdog_timeout_irq;
            1: return wdog_reset_req;
            2: return cpu_idle;
            3: return clocks_halted;
            default: return ring_clk_sel;
        endcase
    endfunction
    task wait_sig(input int s, input logic lvl, input int lim);
        n = 0;
        #1;
        while (pick(s) !== lvl) begin
            if (n == lim) begin
                err_total++;
                complete_run();
            end
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask
    task pin(input logic v);
        @(posedge clk_sys);
        ext_irq_pin <= v;
    endtask
    task scen_reset;
        read_chk("power", 8'h87, 8'h00);
        read_chk("ext flags", 8'h91, 8'h00);
        read_chk("wdog ctl", 8'hd8, 8'h00);
        read_chk("unmapped", 8'h00, 8'h00);
        check8("bandgap", 8'h01, {7'h00, bandgap_on});
    endtask
    task scen_idle;
        sfr_wr(8'h87, 8'h01);
        wait_sig(2, 1'b1, 4);
        check8("bandgap idle", 8'h01, {7'h00, bandgap_on});
        @(posedge clk_sys);
        other_irq_pending <= 1'b1;
        wait_sig(2, 1'b0, 5);
        @(posedge clk_sys);
        other_irq_pending <= 1'b0;
    endtask
    task scen_stop;
        sfr_wr(8'h91, 8'h02);
        sfr_wr(8'h87, 8'h02);
        wait_sig(3, 1'b1, 4);
        check8("bandgap stop", 8'h00, {7'h00, bandgap_on});
        @(posedge clk_sys);
        other_irq_pending <= 1'b1;
        repeat (8) @(posedge clk_sys);
        other_irq_pending <= 1'b0;
        #1;
        check8("stop held", 8'h01, {7'h00, clocks_halted});
        pin(1'b1);
        wait_sig(3, 1'b0, 6);
        check8("ring on", 8'h01, {7'h00, ring_clk_sel});
        wait_sig(4, 1'b0, HAND + 4);
        check8("handover", 8'h01, {7'h00, n >= HAND - 1 && n <= HAND + 1});
        pin(1'b0);
        unlock_wr(8'h91, 8'h03);
        sfr_wr(8'h87, 8'h02);
        wait_sig(3, 1'b1, 4);
        check8("bandgap kept", 8'h01, {7'h00, bandgap_on});
        pin(1'b1);
        wait_sig(3, 1'b0, 6);
        pin(1'b0);
        read_chk("ring mode", 8'h91, 8'h07);
        // back to sleep before the crystal takes over
        sfr_wr(8'h87, 8'h02);
        wait_sig(3, 1'b1, 4);
        check8("ring off stop", 8'h00, {7'h00, ring_clk_sel});
        pin(1'b1);
        wait_sig(3, 1'b0, 6);
        pin(1'b0);
        wait_sig(4, 1'b0, HAND + 4);
        read_chk("ring done", 8'h91, 8'h03);
    endtask
    task scen_protect;
        sfr_wr(8'hd8, 8'h02);
        read_chk("no unlock", 8'hd8, 8'h00);
        sfr_wr(8'h8e, 8'h00);
        unlock_wr(8'hd8, 8'h03);
        repeat (20) @(posedge clk_sys);
        #1;
        check8("irq masked", 8'h00, {7'h00, wdog_timeout_irq});
        read_chk("flag masked", 8'hd8, 8'h0a);
        sfr_wr(8'he8, 8'h10);
        #1;
        check8("irq enabled", 8'h01, {7'h00, wdog_timeout_irq});
    endtask
    task scen_interval;
        for (int s = 0; s < 4; s++) begin
            sfr_wr(8'h8e, 8'(s << 6));
            unlock_wr(8'hd8, 8'h03);
            wait_sig(0, 1'b1, 200);
            check8("interval", 8'h01, {7'h00, n >= (16 << s) - 1 && n <= (16 << s) + 1});
            wait_sig(1, 1'b1, GRACE + 4);
            check8("grace", 8'h01, {7'h00, n >= GRACE - 1 && n <= GRACE + 1});
            read_chk("reset flag", 8'hd8, 8'h0e);
        end
    endtask
    // watchdog interrupt ends idle; software restarts before the grace runs out
    task scen_idle_wdog;
        unlock_wr(8'hd8, 8'h03);
        read_chk("restarted", 8'hd8, 8'h02);
        sfr_wr(8'h87, 8'h01);
        wait_sig(2, 1'b1, 4);
        wait_sig(2, 1'b0, 200);
        check8("wake cause", 8'h01, {7'h00, wdog_timeout_irq});
        unlock_wr(8'hd8, 8'h03);
        repeat (GRACE + 4) begin
            @(posedge clk_sys);
            #1;
            check8("no reset", 8'h00, {7'h00, wdog_reset_req});
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        scen_reset();
        scen_idle();
        scen_stop();
        scen_protect();
        scen_interval();
        scen_idle_wdog();
        complete_run();
    end
endmodule // wdp_watchdog_power_tb
